// ==== wdr_top.sv ====
// watchdog control, unlock sequence and reset-cause flags behind an axi4-lite slave
module wdr_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // watchdog environment
    input wire logic osc_tick,
    input wire logic always_on_fuse,
    input wire wdr_pkg::wdr_rst_src_s rst_src,
    input wire wdr_pkg::wdr_cpu_s cpu,
    // requests out
    output logic wdog_irq_req,
    output logic wdog_reset_req,
    output logic irq
);
    import wdr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic level2;
    logic en;
    logic ie;
    logic flag;
    logic [3:0] sel;
    logic [2:0] window_cnt;
    logic [3:0] rc_flags;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;

    // ----------------------------------------------------------------
    // decode and next values
    // ----------------------------------------------------------------
    wire wdr_reg_e wr_reg = wdr_decode(aw_addr);
    wire wdr_reg_e rd_reg = wdr_decode(s_axi_araddr);
    wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_any = wr_fire && w_lane0;
    wire wr_ctrl = wr_any && (wr_reg == REG_CTRL);
    wire wr_rc = wr_any && (wr_reg == REG_RC);
    wire wr_unlock = wr_any && (wr_reg == REG_UNLOCK);
    wire wr_irq_st = wr_any && (wr_reg == REG_IRQ_ST);
    wire wr_irq_mk = wr_any && (wr_reg == REG_IRQ_MK);
    wire [3:0] w_sel = {w_byte[CTRL_SEL3_BIT], w_byte[2:0]};
    wire unlocked = (window_cnt != 3'h0);
    wire chip = rst_src.chip;

    wire en_eff = en || level2;
    wire running = en_eff || ie;
    wire timeout;
    wire timer_clear = sys_rst || chip || cpu.restart || !running;
    wire to_irq = timeout && ie;
    wire to_reset = timeout && en_eff && !ie;

    wire refused = wr_ctrl && !unlocked
        && ((!level2 && en && !w_byte[CTRL_EN_BIT]) || (level2 && (w_sel != sel)));

    // enable set freely; clear only unlocked
    wire next_en = chip ? 1'b0
        : (wr_ctrl && !level2 && w_byte[CTRL_EN_BIT]) ? 1'b1
        : (wr_ctrl && !level2 && unlocked) ? 1'b0 : en;
    wire [3:0] next_sel = chip ? SEL_RESET_VAL
        : (wr_ctrl && (!level2 || unlocked)) ? w_sel : sel;
    // first time-out drops irq enable while reset is enabled; a write in that cycle wins
    wire next_ie = chip ? 1'b0 : wr_ctrl ? w_byte[CTRL_IE_BIT]
        : (to_irq && en_eff) ? 1'b0 : ie;
    wire next_flag = chip ? 1'b0 : to_irq ? 1'b1
        : (cpu.vector_taken || (wr_ctrl && w_byte[CTRL_FLAG_BIT])) ? 1'b0 : flag;
    // signature opens window; one control write or expiry closes it
    wire [2:0] next_window = chip ? 3'h0
        : (wr_unlock && (w_byte == UNLOCK_SIGNATURE)) ? UNLOCK_WINDOW_CYC
        : wr_ctrl ? 3'h0 : unlocked ? window_cnt - 3'h1 : window_cnt;

    wire [3:0] rc_set = {to_reset, rst_src.brownout, rst_src.pin, 1'b0};
    wire [3:0] rc_clr = wr_rc ? ~w_byte[3:0] : 4'h0;
    wire [3:0] next_rc;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rc
            assign next_rc[gi] = rc_set[gi] || (rc_flags[gi] && !rc_clr[gi]);
        end
    endgenerate

    wire [IRQ_W-1:0] irq_evt = {refused, to_reset, to_irq};
    wire [IRQ_W-1:0] irq_clr = wr_irq_st ? w_byte[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] next_irq_status = irq_evt | (irq_status & ~irq_clr);
    wire [IRQ_W-1:0] next_irq_mask = wr_irq_mk ? w_byte[IRQ_W-1:0] : irq_mask;

    // bit 4 and upper cause bits read zero
    wire [7:0] ctrl_rd = {flag, ie, sel[3], 1'b0, en_eff, sel[2:0]};
    wire [7:0] rd_byte = (rd_reg == REG_CTRL) ? ctrl_rd
        : (rd_reg == REG_RC) ? {4'h0, rc_flags}
        : (rd_reg == REG_IRQ_ST) ? {5'h00, irq_status}
        : (rd_reg == REG_IRQ_MK) ? {5'h00, irq_mask} : 8'h00;
    wire [1:0] rd_resp = (rd_reg == REG_NONE) ? RESP_DECERR : RESP_OKAY;
    wire [1:0] wr_resp = (wr_reg == REG_NONE) ? RESP_DECERR : RESP_OKAY;

    // ----------------------------------------------------------------
    // period counter
    // ----------------------------------------------------------------
    wdr_timer u_timer (
        .sys_clk(sys_clk),
        .clear(timer_clear),
        .osc_tick(osc_tick),
        .select(sel),
        .timeout(timeout)
    );

    // ----------------------------------------------------------------
    // fuse capture
    // ----------------------------------------------------------------
    // level latched while reset is held
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            level2 <= always_on_fuse;
        end
    end

    // ----------------------------------------------------------------
    // control and flag registers
    // ----------------------------------------------------------------
    // power-up leaves only bit 0 set
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            en <= 1'b0;
            ie <= 1'b0;
            flag <= 1'b0;
            sel <= SEL_RESET_VAL;
            window_cnt <= 3'h0;
            rc_flags <= RC_RESET_VAL;
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            en <= next_en;
            ie <= next_ie;
            flag <= next_flag;
            sel <= next_sel;
            window_cnt <= next_window;
            rc_flags <= next_rc;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // request outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wdog_irq_req <= 1'b0;
            wdog_reset_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            wdog_irq_req <= flag && ie && cpu.global_ie;
            wdog_reset_req <= to_reset;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    // address and data are latched independently, so either may come first
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_resp;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_level1_free_enable: assert property (
        @(posedge sys_clk) disable iff (sys_rst || chip)
        (wr_ctrl && !level2 && w_byte[CTRL_EN_BIT]) |=> en ##0 ctrl_rd[CTRL_EN_BIT]
    ) else $error("level 1 enable write not taken");

    a_unlock_opens_window: assert property (
        @(posedge sys_clk) disable iff (sys_rst || chip)
        (wr_unlock && (w_byte == UNLOCK_SIGNATURE)) |=> (window_cnt == 3'h4)
            ##1 (window_cnt == 3'h3 || window_cnt == 3'h0)
    ) else $error("unlock window not opened for four cycles");

    a_level2_reads_one: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        level2 |-> ctrl_rd[CTRL_EN_BIT] && running
    ) else $error("level 2 watchdog not running");

    a_level2_sel_locked: assert property (
        @(posedge sys_clk) disable iff (sys_rst || chip)
        (level2 && wr_ctrl && !unlocked) |=> (sel == $past(sel))
    ) else $error("level 2 select changed without unlock");

    a_locked_no_disable: assert property (
        @(posedge sys_clk) disable iff (sys_rst || chip)
        (!level2 && en && wr_ctrl && !unlocked && !w_byte[CTRL_EN_BIT])
            |=> en ##0 irq_status[IRQ_REFUSED]
    ) else $error("locked disable was not refused");

    a_pin_flag_sets: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rst_src.pin |=> rc_flags[RC_PIN]
    ) else $error("pin reset flag not set");

    a_powerup_flag_holds: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (rc_flags[RC_POWERUP] && !(wr_rc && !w_byte[RC_POWERUP])) |=> rc_flags[RC_POWERUP]
    ) else $error("power-up flag lost without a zero write");

    a_timeout_sets_flag: assert property (
        @(posedge sys_clk) disable iff (sys_rst || chip)
        to_irq |=> flag ##1 (wdog_irq_req == ($past(ie) && $past(cpu.global_ie)))
    ) else $error("time-out flag or request wrong");

    a_ie_auto_clear: assert property (
        @(posedge sys_clk) disable iff (sys_rst || chip)
        (to_irq && en_eff && !wr_ctrl) |=> !ie ##0 flag ##0 !wdog_reset_req
    ) else $error("irq enable not dropped on first time-out");

    a_reset_on_timeout: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        to_reset |=> wdog_reset_req ##0 rc_flags[RC_WDOG] ##1 !wdog_reset_req
    ) else $error("reset time-out not reported");

endmodule // wdr_top

// ==== wdr_pkg.sv ====
// package: register map, field layout and shared types of the watchdog block
package wdr_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_WDOG_CTRL = 8'h30;
    localparam logic [7:0] IDX_RESET_CAUSE = 8'h35;
    localparam logic [7:0] ADDR_WDOG_CTRL = {IDX_WDOG_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_RESET_CAUSE = {IDX_RESET_CAUSE[5:0], 2'b00};
    localparam logic [7:0] ADDR_UNLOCK = 8'hE0;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE4;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hE8;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_FLAG_BIT = 7;
    localparam int CTRL_IE_BIT = 6;
    localparam int CTRL_SEL3_BIT = 5;
    localparam int CTRL_EN_BIT = 3;
    localparam int RC_POWERUP = 0;
    localparam int RC_PIN = 1;
    localparam int RC_BROWNOUT = 2;
    localparam int RC_WDOG = 3;
    localparam logic [3:0] RC_RESET_VAL = 4'h1;
    localparam logic [3:0] SEL_RESET_VAL = 4'h0;
    localparam int IRQ_W = 3;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_WDOG_RST = 1;
    localparam int IRQ_REFUSED = 2;

    // ----------------------------------------------------------------
    // protection, timing and counter constants
    // ----------------------------------------------------------------
    localparam logic [7:0] UNLOCK_SIGNATURE = 8'hD8;
    localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
    localparam logic [3:0] SEL_LAST_VALID = 4'h9;
    localparam int CNT_W = 18;
    localparam logic [18:0] CNT_BASE = 19'h00200;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        REG_NONE = 5'h00,
        REG_CTRL = 5'h01,
        REG_RC = 5'h02,
        REG_UNLOCK = 5'h04,
        REG_IRQ_ST = 5'h08,
        REG_IRQ_MK = 5'h10
    } wdr_reg_e;

    typedef struct packed {
        logic chip;
        logic pin;
        logic brownout;
    } wdr_rst_src_s;

    typedef struct packed {
        logic restart;
        logic vector_taken;
        logic global_ie;
    } wdr_cpu_s;

    function automatic wdr_reg_e wdr_decode(input logic [7:0] addr);
        unique case (addr)
            ADDR_WDOG_CTRL: return REG_CTRL;
            ADDR_RESET_CAUSE: return REG_RC;
            ADDR_UNLOCK: return REG_UNLOCK;
            ADDR_IRQ_STATUS: return REG_IRQ_ST;
            ADDR_IRQ_MASK: return REG_IRQ_MK;
            default: return REG_NONE;
        endcase
    endfunction

    // reserved codes fold onto the longest legal period
    function automatic logic [3:0] wdr_sel_map(input logic [3:0] sel);
        return (sel > SEL_LAST_VALID) ? SEL_LAST_VALID : sel;
    endfunction

    function automatic logic [CNT_W-1:0] wdr_period_last(input logic [3:0] sel);
        logic [18:0] p;
        p = (CNT_BASE << wdr_sel_map(sel)) - 19'h00001;
        return p[CNT_W-1:0];
    endfunction

endpackage

// ==== wdr_timer.sv ====
// watchdog period counter, advanced by the low-power oscillator tick
module wdr_timer (
    // clock
    input wire logic sys_clk,
    // control
    input wire logic clear,
    input wire logic osc_tick,
    input wire logic [3:0] select,
    // result
    output logic timeout
);
    import wdr_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] last;

    assign last = wdr_period_last(select);
    assign timeout = osc_tick && !clear && (count == last);

    always_ff @(posedge sys_clk) begin
        if (clear || timeout) begin
            count <= '0;
        end else if (osc_tick) begin
            count <= count + 1'b1;
        end
    end

    a_tick_only_count: assert property (
        @(posedge sys_clk) disable iff (clear)
        !osc_tick |=> (count == $past(count))
    ) else $error("counter moved without an oscillator tick");

    a_timeout_at_period: assert property (
        @(posedge sys_clk) disable iff (clear)
        timeout |-> (count == wdr_period_last(select)) ##1 (count == '0)
    ) else $error("time-out not at the selected period");

    a_clear_zeroes: assert property (
        @(posedge sys_clk)
        clear |=> (count == '0)
    ) else $error("counter not cleared");

endmodule // wdr_timer

// ==== wdr_core_model.sv ====
// behavioural model of the processor core and oscillator around the watchdog
module wdr_core_model
    import wdr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // scenario control
    input wire logic tick_on,
    input wire logic tick_slow,
    input wire logic restart_cmd,
    input wire logic gie,
    input wire logic take_vec,
    // watchdog side
    input wire logic wdog_irq_req,
    output logic osc_tick,
    output wdr_pkg::wdr_cpu_s cpu
);
    timeunit 1ns;
    timeprecision 1ns;

    logic phase;

    initial begin
        phase = 1'b0;
        osc_tick = 1'b0;
        cpu = '0;
    end

    always @(posedge sys_clk) begin
        phase <= sys_rst ? 1'b0 : ~phase;
        // oscillator tick source
        // slow mode halves the tick rate to show the period follows the oscillator only
        osc_tick <= tick_on && (!tick_slow || phase);
        cpu.restart <= restart_cmd;
        cpu.vector_taken <= take_vec && gie && wdog_irq_req && !cpu.vector_taken;
        cpu.global_ie <= gie;
    end
endmodule // wdr_core_model

// ==== watchdog_and_reset_cause_test.sv ====
// self-checking testbench of the watchdog and reset-cause block
module watchdog_and_reset_cause_test;
    timeunit 1ns;
    timeprecision 1ns;
    import wdr_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0, sys_rst = 1'b1, fuse = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic osc_tick, wdog_irq_req, wdog_reset_req, irq;
    wdr_cpu_s cpu;
    wdr_rst_src_s rst_src = '0;
    logic tick_on = 1'b0, tick_slow = 1'b0, restart_cmd = 1'b0, gie = 1'b0, take_vec = 1'b0;
    int num_errors = 0, compares = 0, cycles = 0, rst_seen = 0, seen0;

    always #25 sys_clk = ~sys_clk;

    wdr_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'b1), .osc_tick(osc_tick), .always_on_fuse(fuse), .rst_src(rst_src),
        .cpu(cpu), .wdog_irq_req(wdog_irq_req), .wdog_reset_req(wdog_reset_req), .irq(irq));

    wdr_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .tick_on(tick_on),
        .tick_slow(tick_slow), .restart_cmd(restart_cmd), .gie(gie), .take_vec(take_vec),
        .wdog_irq_req(wdog_irq_req), .osc_tick(osc_tick), .cpu(cpu));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bready is held high, so the answer is taken at the edge it is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic aw_open, w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (aw_open && s_axi_awready) begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_open && s_axi_wready) begin
                w_open = 1'b0;
                wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && s_axi_arready)
                arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk("rdata", {24'h0, exp}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic pulse_src(input logic [2:0] v);
        rst_src <= wdr_rst_src_s'(v);
        @(posedge sys_clk);
        rst_src <= '0;
        @(posedge sys_clk);
    endtask

    // which: 0 reset request, 1 interrupt request, 2 interrupt line
    task automatic wait_for(input int which, input int lo, input int hi, input string name);
        int n;
        n = 0;
        while (!(which == 0 ? wdog_reset_req : which == 1 ? wdog_irq_req : irq) && n < hi) begin
            @(posedge sys_clk);
            n++;
        end
        chk(name, 32'h1, {31'h0, (n >= lo && n < hi)});
    endtask

    task automatic unlock_ctrl(input logic [7:0] d);
        wr(ADDR_UNLOCK, UNLOCK_SIGNATURE);
        wr(ADDR_WDOG_CTRL, d);
    endtask

    // ----------------------------------------------------------------
    // timeout and reset-request monitor
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (wdog_reset_req === 1'b1)
            rst_seen++;
        if (cycles == 40000) begin
            num_errors++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_WDOG_CTRL, 8'h00);
        rd(ADDR_RESET_CAUSE, 8'h01);
        rd(8'h04, 8'h00, RESP_DECERR);
        wr(8'h04, 8'hFF, RESP_DECERR);
        pulse_src(3'b010);
        pulse_src(3'b001);
        rd(ADDR_RESET_CAUSE, 8'h07);
        wr(ADDR_RESET_CAUSE, 8'h0E);
        rd(ADDR_RESET_CAUSE, 8'h06);
        wr(ADDR_RESET_CAUSE, 8'hF0);
        rd(ADDR_RESET_CAUSE, 8'h00);
        wr(ADDR_WDOG_CTRL, 8'h10);
        rd(ADDR_WDOG_CTRL, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h07);
        // reset mode, shortest period at one tick a cycle
        tick_on <= 1'b1;
        wr(ADDR_WDOG_CTRL, 8'h08);
        wait_for(0, 500, 525, "reset_period");
        rd(ADDR_RESET_CAUSE, 8'h08);
        pulse_src(3'b100);
        rd(ADDR_WDOG_CTRL, 8'h00);
        wr(ADDR_WDOG_CTRL, 8'h08);
        seen0 = rst_seen;
        repeat (4) begin
            repeat (400) @(posedge sys_clk);
            restart_cmd <= 1'b1;
            @(posedge sys_clk);
            restart_cmd <= 1'b0;
        end
        chk("restart_holds", seen0, rst_seen);
        wr(ADDR_IRQ_STATUS, 8'h07);
        wr(ADDR_WDOG_CTRL, 8'h00);
        rd(ADDR_WDOG_CTRL, 8'h08);
        rd(ADDR_IRQ_STATUS, 8'h04);
        wr(ADDR_UNLOCK, UNLOCK_SIGNATURE);
        repeat (8) @(posedge sys_clk);
        wr(ADDR_WDOG_CTRL, 8'h00);
        rd(ADDR_WDOG_CTRL, 8'h08);
        unlock_ctrl(8'h08);
        wr(ADDR_WDOG_CTRL, 8'h00);
        rd(ADDR_WDOG_CTRL, 8'h08);
        unlock_ctrl(8'h00);
        rd(ADDR_WDOG_CTRL, 8'h00);
        // reserved select folds onto a long legal period
        wr(ADDR_WDOG_CTRL, 8'h2F);
        seen0 = rst_seen;
        repeat (3000) @(posedge sys_clk);
        chk("reserved_sel", seen0, rst_seen);
        unlock_ctrl(8'h00);
        // no oscillator ticks, no time-out
        tick_on <= 1'b0;
        wr(ADDR_WDOG_CTRL, 8'h08);
        repeat (1500) @(posedge sys_clk);
        chk("no_tick", seen0, rst_seen);
        wr(ADDR_IRQ_STATUS, 8'h07);
        gie <= 1'b1;
        tick_on <= 1'b1;
        wr(ADDR_WDOG_CTRL, 8'h48);
        // irq enable drops with this time-out, so only the status line shows it
        wait_for(2, 490, 525, "irq_first");
        rd(ADDR_WDOG_CTRL, 8'h88);
        chk("irq_line", 32'h1, {31'h0, irq});
        wr(ADDR_WDOG_CTRL, 8'h88);
        rd(ADDR_WDOG_CTRL, 8'h08);
        wr(ADDR_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk("irq_line", 32'h0, {31'h0, irq});
        wait_for(0, 0, 525, "reset_second");
        pulse_src(3'b100);
        // interrupt mode, held off by the global enable
        gie <= 1'b0;
        wr(ADDR_IRQ_STATUS, 8'h07);
        wr(ADDR_WDOG_CTRL, 8'h40);
        wait_for(2, 490, 525, "irq_only");
        chk("no_req", 32'h0, {31'h0, wdog_irq_req});
        gie <= 1'b1;
        take_vec <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("irq_req", 32'h1, {31'h0, wdog_irq_req});
        repeat (3) @(posedge sys_clk);
        rd(ADDR_WDOG_CTRL, 8'h40);
        wr(ADDR_WDOG_CTRL, 8'h00);
        // safety level 2
        tick_on <= 1'b0;
        take_vec <= 1'b0;
        fuse <= 1'b1;
        sys_rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_WDOG_CTRL, 8'h08);
        rd(ADDR_RESET_CAUSE, 8'h01);
        wr(ADDR_WDOG_CTRL, 8'h00);
        rd(ADDR_WDOG_CTRL, 8'h08);
        wr(ADDR_WDOG_CTRL, 8'h01);
        rd(ADDR_WDOG_CTRL, 8'h08);
        unlock_ctrl(8'h01);
        rd(ADDR_WDOG_CTRL, 8'h09);
        tick_slow <= 1'b1;
        tick_on <= 1'b1;
        wait_for(0, 2030, 2075, "level2_period");
        test_done();
    end
endmodule // watchdog_and_reset_cause_test
